// *** src/five_timer_counter_unit.sv ***
/*
 * Top of the five timer/counter unit: two legacy timers and three wide
 * timers, machine-cycle and peripheral-clock dividers, toggle outputs,
 * sticky overflow flags. All control and status bits are plain ports.
 * Assumes all pin inputs are already synchronous to clk.
 */
`timescale 1ns/1ps
// Summary of operation
// RQ1: Legacy timers in timer function step once per machine cycle.
// RQ2: Legacy counters step on falling count pin, sampled each machine cycle.
// RQ3: Legacy timers offer modes 0, 1, 2, 3 and 6.
// RQ4: Mode 0 is an 8-bit counter behind a divide-by-32 prescaler.
// RQ5: Mode 1 uses all sixteen count bits.
// RQ6: Mode 2 is an 8-bit counter reloading on overflow.
// RQ7: Second legacy timer stops counting in mode 3.
// RQ8: First legacy timer in mode 3 splits into two 8-bit counters.
// RQ9: Second legacy timer still feeds baud overflow in mode 3.
// RQ10: Mode 6 is a PWM with a 256-machine-cycle (512-clock) period.
// RQ11: Legacy toggle output inverts on each overflow on the count pin.
// RQ12: Toggle outputs sit high until the first overflow after enable.
// RQ13: Wide timers step once per peripheral clock in timer function.
// RQ14: Wide counters step on falling count pin, sampled each machine cycle.
// RQ15: Each wide timer has a trigger pin whose falling edge acts.
// RQ16: Wide timers offer modes 0, 1 and 2.
// RQ17: Wide mode 0 reloads on overflow or trigger falling edge.
// RQ18: Wide mode 1 captures the count on trigger falling edge.
// RQ19: Wide mode 2 is PWM with programmable duty and period.
// RQ20: Wide toggle output inverts on each overflow on the count pin.
// RQ21: Each timer sets a sticky overflow flag software can clear.
module five_timer_counter_unit (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [1:0]  legacy_run,
    input  wire logic [1:0]  legacy_counter_mode,
    input  wire logic [2:0]  legacy_a_mode,
    input  wire logic [2:0]  legacy_b_mode,
    input  wire logic [15:0] legacy_a_load_value,
    input  wire logic [15:0] legacy_b_load_value,
    input  wire logic [1:0]  legacy_load,
    input  wire logic [1:0]  legacy_toggle_enable,
    input  wire logic        legacy_timer_a_pin,
    input  wire logic        legacy_timer_b_pin,
    input  wire logic [2:0]  wide_run,
    input  wire logic [2:0]  wide_counter_mode,
    input  wire logic [5:0]  wide_mode,
    input  wire logic [47:0] wide_reload_value,
    input  wire logic [47:0] wide_duty_value,
    input  wire logic [2:0]  wide_trigger_enable,
    input  wire logic [2:0]  wide_toggle_enable,
    input  wire logic        wide_timer_a_pin,
    input  wire logic        wide_timer_b_pin,
    input  wire logic        wide_timer_c_pin,
    input  wire logic [2:0]  wide_timer_trigger_pin,
    input  wire logic [5:0]  ovf_flag_clear,
    output logic [15:0]      legacy_a_count,
    output logic [15:0]      legacy_b_count,
    output logic [47:0]      wide_count,
    output logic [47:0]      wide_capture,
    output logic [5:0]       ovf_flag,
    output logic             baud_overflow,
    output logic [1:0]       legacy_toggle_out,
    output logic [2:0]       wide_toggle_out,
    output logic [1:0]       legacy_pwm_out,
    output logic [2:0]       wide_pwm_out
);
    // Flag order: legacy a low, legacy a high byte, legacy b, wide a, b, c
    logic        machine_tick;
    logic        pclk_tick;
    logic        mdiv;
    logic [15:0] leg_count [2];
    logic [1:0]  leg_ovf;
    logic        leg_a_ovf_high;
    logic [1:0]  leg_pwm;
    logic [2:0]  wid_ovf;
    logic [2:0]  wid_pwm;
    logic [15:0] wid_count [3];
    logic [15:0] wid_cap [3];
    logic [2:0]  wide_pins;
    logic [1:0]  leg_tog_en_prev;
    logic [2:0]  wid_tog_en_prev;
    logic [5:0]  events;

    // The enable logic below is hard-wired for these two divider ratios
    if (timer_unit_pkg::MACHINE_DIV != 2 || timer_unit_pkg::PCLK_DIV != 1) begin : g_bad_div
        $error("Divider settings not supported");
    end

    // Machine cycle enable: one pulse every two clocks
    always_ff @(posedge clk) begin
        if (!rst_n)
            mdiv <= 1'b0;
        else
            mdiv <= ~mdiv;
    end
    assign machine_tick = mdiv;
    assign pclk_tick    = 1'b1; // [RQ13]

    // [RQ3]
    legacy_timer #(.IS_SECOND(1'b0)) u_leg_a (
        .clk          (clk),
        .rst_n        (rst_n),
        .tick         (machine_tick),
        .run          (legacy_run[0]),
        .counter_mode (legacy_counter_mode[0]),
        .mode         (legacy_a_mode),
        .count_pin    (legacy_timer_a_pin),
        .load_value   (legacy_a_load_value),
        .load         (legacy_load[0]),
        .count        (leg_count[0]),
        .ovf          (leg_ovf[0]),
        .ovf_high     (leg_a_ovf_high),
        .pwm          (leg_pwm[0])
    );

    legacy_timer #(.IS_SECOND(1'b1)) u_leg_b (
        .clk          (clk),
        .rst_n        (rst_n),
        .tick         (machine_tick),
        .run          (legacy_run[1]),
        .counter_mode (legacy_counter_mode[1]),
        .mode         (legacy_b_mode),
        .count_pin    (legacy_timer_b_pin),
        .load_value   (legacy_b_load_value),
        .load         (legacy_load[1]),
        .count        (leg_count[1]),
        .ovf          (leg_ovf[1]),
        .ovf_high     (),
        .pwm          (leg_pwm[1])
    );

    assign wide_pins = {wide_timer_c_pin, wide_timer_b_pin, wide_timer_a_pin};

    // [RQ16]
    for (genvar i = 0; i < 3; i++) begin : g_wide
        wide_timer u_wide (
            .clk            (clk),
            .rst_n          (rst_n),
            .tick           (pclk_tick),
            .sample         (machine_tick),
            .run            (wide_run[i]),
            .counter_mode   (wide_counter_mode[i]),
            .mode           (wide_mode[2*i +: 2]),
            .count_pin      (wide_pins[i]),
            .trigger_pin    (wide_timer_trigger_pin[i]),
            .trigger_enable (wide_trigger_enable[i]),
            .reload_value   (wide_reload_value[16*i +: 16]),
            .duty_value     (wide_duty_value[16*i +: 16]),
            .count          (wid_count[i]),
            .capture        (wid_cap[i]),
            .ovf            (wid_ovf[i]),
            .pwm            (wid_pwm[i])
        );
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            legacy_a_count <= timer_unit_pkg::COUNT_RESET;
            legacy_b_count <= timer_unit_pkg::COUNT_RESET;
            wide_count     <= 48'h000000000000;
            wide_capture   <= 48'h000000000000;
            legacy_pwm_out <= 2'h0;
            wide_pwm_out   <= 3'h0;
        end else begin
            legacy_a_count <= leg_count[0];
            legacy_b_count <= leg_count[1];
            wide_count     <= {wid_count[2], wid_count[1], wid_count[0]};
            wide_capture   <= {wid_cap[2], wid_cap[1], wid_cap[0]};
            legacy_pwm_out <= leg_pwm;
            wide_pwm_out   <= wid_pwm;
        end
    end

    // Overflow of the second timer reaches the serial port in every mode [RQ9]
    always_ff @(posedge clk) begin
        if (!rst_n)
            baud_overflow <= 1'b0;
        else
            baud_overflow <= leg_ovf[1] ||
                (legacy_b_mode == timer_unit_pkg::LEG_MODE_SPLIT && legacy_run[1] &&
                 machine_tick && leg_count[1][7:0] == 8'hFF);
    end

    // Rising enable forces the pin high; each overflow then inverts it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            leg_tog_en_prev   <= 2'h0;
            legacy_toggle_out <= {2{timer_unit_pkg::TOGGLE_RESET}};
        end else begin
            leg_tog_en_prev <= legacy_toggle_enable;
            for (int i = 0; i < 2; i++) begin
                if (legacy_toggle_enable[i] && !leg_tog_en_prev[i])
                    legacy_toggle_out[i] <= 1'b1; // [RQ12]
                else if (legacy_toggle_enable[i] && leg_ovf[i])
                    legacy_toggle_out[i] <= ~legacy_toggle_out[i]; // [RQ11]
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wid_tog_en_prev <= 3'h0;
            wide_toggle_out <= {3{timer_unit_pkg::TOGGLE_RESET}};
        end else begin
            wid_tog_en_prev <= wide_toggle_enable;
            for (int i = 0; i < 3; i++) begin
                if (wide_toggle_enable[i] && !wid_tog_en_prev[i])
                    wide_toggle_out[i] <= 1'b1; // [RQ12]
                else if (wide_toggle_enable[i] && wid_ovf[i])
                    wide_toggle_out[i] <= ~wide_toggle_out[i]; // [RQ20]
            end
        end
    end

    assign events = {wid_ovf, leg_ovf[1], leg_a_ovf_high, leg_ovf[0]};

    // Set beats clear so an overflow in the clearing cycle survives
    always_ff @(posedge clk) begin
        if (!rst_n)
            ovf_flag <= 6'h00;
        else
            ovf_flag <= (ovf_flag & ~ovf_flag_clear) | events; // [RQ21]
    end
endmodule : five_timer_counter_unit

// *** src/timer_unit_pkg.sv ***
/*
 * Shared constants for the five timer/counter unit: legacy and wide timer
 * mode codes, reset values and divider counts.
 * Assumes a single 100 MHz clock; slower rates are enable pulses.
 */
package timer_unit_pkg;
    localparam int          CLK_MHZ           = 100;
    // Machine cycle is two core clocks; peripheral clock is one core clock
    localparam int          MACHINE_DIV       = 2;
    localparam int          PCLK_DIV          = 1;
    localparam logic [2:0]  LEG_MODE_13BIT    = 3'h0;
    localparam logic [2:0]  LEG_MODE_16BIT    = 3'h1;
    localparam logic [2:0]  LEG_MODE_RELOAD   = 3'h2;
    localparam logic [2:0]  LEG_MODE_SPLIT    = 3'h3;
    localparam logic [2:0]  LEG_MODE_PWM      = 3'h6;
    localparam logic [1:0]  WIDE_MODE_RELOAD  = 2'h0;
    localparam logic [1:0]  WIDE_MODE_CAPTURE = 2'h1;
    localparam logic [1:0]  WIDE_MODE_PWM     = 2'h2;
    localparam int          PRESCALE_BITS     = 5;
    localparam logic [15:0] COUNT_RESET       = 16'h0000;
    localparam logic        TOGGLE_RESET      = 1'b1;
endpackage : timer_unit_pkg

// *** src/legacy_timer.sv ***
/*
 * One legacy-compatible timer/counter with modes 0, 1, 2, 3 and 6.
 * Assumes tick is a one-cycle enable and count_pin is synchronous.
 */
`timescale 1ns/1ps
module legacy_timer #(
    parameter bit IS_SECOND = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        tick,
    input  wire logic        run,
    input  wire logic        counter_mode,
    input  wire logic [2:0]  mode,
    input  wire logic        count_pin,
    input  wire logic [15:0] load_value,
    input  wire logic        load,
    output logic [15:0]      count,
    output logic             ovf,
    output logic             ovf_high,
    output logic             pwm
);
    logic        pin_prev;
    logic        step;
    logic [15:0] next_count;
    logic        next_ovf;
    logic        next_ovf_high;

    always_ff @(posedge clk) begin
        if (!rst_n)
            pin_prev <= 1'b1;
        else if (tick)
            pin_prev <= count_pin;
    end

    // [RQ1] [RQ2]
    assign step = tick && run && (counter_mode ? (pin_prev && !count_pin) : 1'b1);

    always_comb begin
        next_count    = count;
        next_ovf      = 1'b0;
        next_ovf_high = 1'b0;
        if (step) begin
            case (mode)
                timer_unit_pkg::LEG_MODE_13BIT: begin // [RQ4]
                    next_count[4:0] = count[4:0] + 5'h01;
                    if (count[4:0] == 5'h1F) begin
                        next_count[15:8] = count[15:8] + 8'h01;
                        next_ovf = (count[15:8] == 8'hFF);
                    end
                end
                timer_unit_pkg::LEG_MODE_16BIT: begin // [RQ5]
                    next_count = count + 16'h0001;
                    next_ovf   = (count == 16'hFFFF);
                end
                timer_unit_pkg::LEG_MODE_RELOAD: begin // [RQ6]
                    next_ovf = (count[7:0] == 8'hFF);
                    next_count[7:0] = next_ovf ? count[15:8] : count[7:0] + 8'h01;
                end
                timer_unit_pkg::LEG_MODE_SPLIT: begin
                    if (!IS_SECOND) begin // [RQ8]
                        next_count[7:0] = count[7:0] + 8'h01;
                        next_ovf = (count[7:0] == 8'hFF);
                        next_count[15:8] = count[15:8] + 8'h01;
                        next_ovf_high = (count[15:8] == 8'hFF);
                    end
                    // Second timer holds its count in split mode [RQ7]
                end
                timer_unit_pkg::LEG_MODE_PWM: begin // [RQ10]
                    next_count[7:0] = count[7:0] + 8'h01;
                    next_ovf = (count[7:0] == 8'hFF);
                end
                default: next_count = count;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count    <= timer_unit_pkg::COUNT_RESET;
            ovf      <= 1'b0;
            ovf_high <= 1'b0;
        end else if (load) begin
            count    <= load_value;
            ovf      <= 1'b0;
            ovf_high <= 1'b0;
        end else begin
            count    <= next_count;
            ovf      <= next_ovf;
            ovf_high <= next_ovf_high;
        end
    end

    // Duty held in the high byte; low byte sweeps the 256-machine-cycle period [RQ10]
    always_ff @(posedge clk) begin
        if (!rst_n)
            pwm <= 1'b0;
        else
            pwm <= (mode == timer_unit_pkg::LEG_MODE_PWM) && (count[7:0] < count[15:8]);
    end
endmodule : legacy_timer

// *** src/wide_timer.sv ***
/*
 * One 16-bit timer/counter with reload, capture and PWM modes.
 * Assumes tick is a one-cycle enable and pins are synchronous.
 */
`timescale 1ns/1ps
module wide_timer (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        tick,
    input  wire logic        sample,
    input  wire logic        run,
    input  wire logic        counter_mode,
    input  wire logic [1:0]  mode,
    input  wire logic        count_pin,
    input  wire logic        trigger_pin,
    input  wire logic        trigger_enable,
    input  wire logic [15:0] reload_value,
    input  wire logic [15:0] duty_value,
    output logic [15:0]      count,
    output logic [15:0]      capture,
    output logic             ovf,
    output logic             pwm
);
    logic pin_prev;
    logic trig_prev;
    logic pin_fall;
    logic trig_fall;
    logic step;
    logic wrap;

    // Both pins sampled once per machine cycle [RQ14]
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_prev  <= 1'b1;
            trig_prev <= 1'b1;
        end else if (sample) begin
            pin_prev  <= count_pin;
            trig_prev <= trigger_pin;
        end
    end

    assign pin_fall  = sample && pin_prev && !count_pin;
    assign trig_fall = sample && trig_prev && !trigger_pin && trigger_enable; // [RQ15]
    assign step      = run && (counter_mode ? pin_fall : tick); // [RQ13] [RQ14]
    // PWM period ends at the reload value, giving programmable full period
    assign wrap      = (mode == timer_unit_pkg::WIDE_MODE_PWM) ? (count == reload_value)
                                                               : (count == 16'hFFFF);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= timer_unit_pkg::COUNT_RESET;
            ovf   <= 1'b0;
        end else begin
            ovf <= step && wrap;
            if (mode == timer_unit_pkg::WIDE_MODE_RELOAD && trig_fall)
                count <= reload_value; // [RQ17]
            else if (step && wrap)
                count <= (mode == timer_unit_pkg::WIDE_MODE_PWM) ? 16'h0000
                                                                  : reload_value; // [RQ17]
            else if (step)
                count <= count + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            capture <= timer_unit_pkg::COUNT_RESET;
        else if (mode == timer_unit_pkg::WIDE_MODE_CAPTURE && trig_fall)
            capture <= count; // [RQ18]
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            pwm <= 1'b0;
        else
            pwm <= (mode == timer_unit_pkg::WIDE_MODE_PWM) && (count < duty_value); // [RQ19]
    end
endmodule : wide_timer

// *** testbench/five_timer_counter_unit_sva.sv ***
/* Port-level assertions for the five timer/counter unit.
   Assumes a machine tick on every second clk edge and registered outputs. */
`timescale 1ns/1ps
module five_timer_counter_unit_sva (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [1:0]  legacy_run,
    input wire logic [1:0]  legacy_counter_mode,
    input wire logic [2:0]  legacy_a_mode,
    input wire logic [2:0]  legacy_b_mode,
    input wire logic [1:0]  legacy_load,
    input wire logic [2:0]  wide_run,
    input wire logic [2:0]  wide_counter_mode,
    input wire logic [5:0]  wide_mode,
    input wire logic [2:0]  wide_trigger_enable,
    input wire logic [2:0]  wide_toggle_enable,
    input wire logic [2:0]  wide_timer_trigger_pin,
    input wire logic [5:0]  ovf_flag_clear,
    input wire logic [15:0] legacy_a_count,
    input wire logic [15:0] legacy_b_count,
    input wire logic [47:0] wide_count,
    input wire logic [47:0] wide_capture,
    input wire logic [5:0]  ovf_flag,
    input wire logic        baud_overflow,
    input wire logic [2:0]  wide_toggle_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic leg_a_free = legacy_run[0] && !legacy_counter_mode[0] && !legacy_load[0]
                            && legacy_a_mode == timer_unit_pkg::LEG_MODE_16BIT;
    wire logic wc_free    = wide_run[2] && !wide_counter_mode[2]
                            && wide_mode[5:4] == timer_unit_pkg::WIDE_MODE_CAPTURE;

    a_reset_values: assert property (disable iff (1'b0) !rst_n [*3] |->
        legacy_a_count == 16'h0000 && ovf_flag == 6'h00 && wide_toggle_out == 3'h7)
        else $error("reset values wrong");
    a_legacy_machine_rate: assert property (leg_a_free [*4] |->
        legacy_a_count == $past(legacy_a_count, 2) + 16'h0001) else $error("legacy rate");
    a_wide_clock_rate: assert property (wc_free [*3] |->
        wide_count[47:32] == $past(wide_count[47:32]) + 16'h0001) else $error("wide rate");
    a_legacy_b_stopped: assert property (
        (legacy_b_mode == timer_unit_pkg::LEG_MODE_SPLIT && !legacy_load[1]) [*3]
        |-> $stable(legacy_b_count)) else $error("timer b moved in mode 3");
    a_flag_sticky: assert property (ovf_flag[3] && !ovf_flag_clear[3] |=> ovf_flag[3])
        else $error("flag lost");
    a_flag_clear: assert property ((ovf_flag_clear[0] && !legacy_run[0]) [*3] |->
        !ovf_flag[0]) else $error("flag not cleared");
    a_toggle_on_ovf: assert property (wide_toggle_enable[0]
        && $past(wide_toggle_enable[0]) && $rose(ovf_flag[3])
        |-> $changed(wide_toggle_out[0])) else $error("no toggle");
    a_toggle_forced_high: assert property ($rose(wide_toggle_enable[1]) |=>
        wide_toggle_out[1]) else $error("toggle not high");
    a_capture_on_trigger: assert property ($fell(wide_timer_trigger_pin[2])
        && wide_run[2] && wide_trigger_enable[2]
        && wide_mode[5:4] == timer_unit_pkg::WIDE_MODE_CAPTURE
        |-> ##[1:6] $changed(wide_capture[47:32])) else $error("no capture");
    a_baud_pulse: assert property (baud_overflow |=> !baud_overflow)
        else $error("baud not a pulse");
endmodule : five_timer_counter_unit_sva

bind five_timer_counter_unit five_timer_counter_unit_sva i_sva (.*);

// *** testbench/event_source_model.sv ***
/* External event source on the count and trigger pins.
   Assumes pulse is called just after a falling edge of clk. */
`timescale 1ns/1ps
module event_source_model (
    input  wire logic clk,
    output logic [7:0] pins
);
    initial pins = 8'hFF;  // Pulled-up pins idle high
    // Each level is held a full machine cycle so a tick sees it
    task automatic pulse(input int k, input int n);
        repeat (n) begin
            pins[k] = 1'b0;
            repeat (2) @(negedge clk);
            pins[k] = 1'b1;
            repeat (2) @(negedge clk);
        end
    endtask : pulse
endmodule : event_source_model

// *** testbench/tb.sv ***
/* Self-checking bench for the five timer/counter unit.
   Assumes registered outputs and a machine tick every second clk. */
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, rst_n = 1'b0;
    logic [1:0] legacy_run = '0, legacy_counter_mode = '0, legacy_load = '0;
    logic [1:0] legacy_toggle_enable = '0, legacy_toggle_out, legacy_pwm_out;
    logic [2:0] legacy_a_mode = '0, legacy_b_mode = '0, wide_run = '0, wide_counter_mode = '0;
    logic [2:0] wide_trigger_enable = '0, wide_toggle_enable = '0, wide_toggle_out, wide_pwm_out;
    logic [5:0] wide_mode = '0, ovf_flag_clear = '0, ovf_flag;
    logic [15:0] legacy_a_load_value = '0, legacy_b_load_value = '0;
    logic [15:0] legacy_a_count, legacy_b_count;
    logic [47:0] wide_reload_value = '0, wide_duty_value = '0, wide_count, wide_capture;
    logic baud_overflow;
    logic [15:0] v, w, hi, ch;
    int n_errors = 0, tests_run = 0, cycles = 0;
    wire logic [7:0] pins;
    wire logic legacy_timer_a_pin = pins[0], legacy_timer_b_pin = pins[1];
    wire logic wide_timer_a_pin = pins[2], wide_timer_b_pin = pins[3], wide_timer_c_pin = pins[4];
    wire logic [2:0] wide_timer_trigger_pin = pins[7:5];
    wire logic [10:0] probe = {wide_pwm_out, legacy_pwm_out, wide_toggle_out,
                               legacy_toggle_out, baud_overflow};

    five_timer_counter_unit i_five_timer_counter_unit (.*);
    event_source_model i_event_source_model (.clk(clk), .pins(pins));

    always #5 clk = ~clk;
    // Whole run is under 3000 cycles; the ceiling only catches a hang
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            complete_run;
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle
    function automatic logic [15:0] cnt(input int k);
        if (k == 0) return legacy_a_count;
        if (k == 1) return legacy_b_count;
        return wide_count[16*(k-2) +: 16];
    endfunction : cnt
    // High cycles and changes of one probe bit over n clocks
    task automatic watch(input int b, input int n);
        logic last;
        hi = 0;
        ch = 0;
        last = probe[b];
        repeat (n) begin
            @(negedge clk);
            hi += probe[b];
            ch += (probe[b] != last);
            last = probe[b];
        end
    endtask : watch
    task automatic load_a(input logic [15:0] val, input logic [2:0] m);
        legacy_a_load_value = val;
        legacy_a_mode = m;
        legacy_load[0] = 1'b1;
        idle(1);
        legacy_load[0] = 1'b0;
        idle(4);
    endtask : load_a

    task automatic t_reset;
        check({10'h0, ovf_flag}, 16'h0000);
        check({11'h0, wide_toggle_out, legacy_toggle_out}, 16'h001F);
        check(legacy_a_count | wide_count[15:0], 16'h0000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_legacy_timer;
        legacy_run[0] = 1'b1;
        load_a(16'h0000, timer_unit_pkg::LEG_MODE_16BIT);
        v = cnt(0);
        idle(20);
        check(cnt(0) - v, 16'd10);
        load_a(16'h0000, timer_unit_pkg::LEG_MODE_13BIT);
        v = cnt(0);
        idle(64);
        w = cnt(0);
        check({w[15:8], w[4:0]} - {v[15:8], v[4:0]}, 16'd32);
        check({13'h0, w[7:5]}, 16'h0000);
        // Both halves wrap inside the window so the high-byte flag is exercised
        load_a(16'hF8F8, timer_unit_pkg::LEG_MODE_SPLIT);
        v = cnt(0);
        idle(20);
        w = cnt(0);
        check({8'h0, w[7:0] - v[7:0]}, 16'd10);
        check({8'h0, w[15:8] - v[15:8]}, 16'd10);
        check({15'h0, ovf_flag[1]}, 16'h0001);
        load_a(16'h4000, timer_unit_pkg::LEG_MODE_PWM);
        watch(6, 512);
        check(hi, 16'd128);
        $display("test legacy timer done");
    endtask : t_legacy_timer
    task automatic t_legacy_b;
        legacy_b_load_value = 16'hFEFE;
        legacy_b_mode = timer_unit_pkg::LEG_MODE_RELOAD;
        legacy_load[1] = 1'b1;
        legacy_run[1] = 1'b1;
        idle(1);
        legacy_load[1] = 1'b0;
        idle(4);
        watch(0, 40);
        check(hi, 16'd10);
        check({15'h0, ovf_flag[2]}, 16'h0001);
        legacy_b_load_value = 16'h00FF;
        legacy_b_mode = timer_unit_pkg::LEG_MODE_SPLIT;
        legacy_load[1] = 1'b1;
        idle(1);
        legacy_load[1] = 1'b0;
        idle(4);
        v = cnt(1);
        watch(0, 20);
        check(hi, 16'd10);
        check(cnt(1), v);
        legacy_run[1] = 1'b0;
        $display("test legacy b done");
    endtask : t_legacy_b
    task automatic t_legacy_counter;
        legacy_counter_mode[0] = 1'b1;
        ovf_flag_clear[0] = 1'b1;  // Flag was left set by the PWM sweep
        load_a(16'h0000, timer_unit_pkg::LEG_MODE_16BIT);
        ovf_flag_clear[0] = 1'b0;
        check({15'h0, ovf_flag[0]}, 16'h0000);
        v = cnt(0);
        i_event_source_model.pulse(0, 5);
        idle(2);
        check(cnt(0) - v, 16'd5);
        legacy_toggle_enable[0] = 1'b1;
        load_a(16'hFFFF, timer_unit_pkg::LEG_MODE_RELOAD);
        check({15'h0, legacy_toggle_out[0]}, 16'h0001);
        i_event_source_model.pulse(0, 3);
        idle(2);
        check({15'h0, legacy_toggle_out[0]}, 16'h0000);
        check({15'h0, ovf_flag[0]}, 16'h0001);
        legacy_run[0] = 1'b0;
        ovf_flag_clear[0] = 1'b1;
        idle(4);
        check({15'h0, ovf_flag[0]}, 16'h0000);
        ovf_flag_clear[0] = 1'b0;
        legacy_toggle_enable[0] = 1'b0;
        idle(1);
        legacy_toggle_enable[0] = 1'b1;
        idle(2);
        check({15'h0, legacy_toggle_out[0]}, 16'h0001);
        $display("test legacy counter done");
    endtask : t_legacy_counter
    task automatic t_wide;
        wide_mode = 6'h20;  // Timer c in PWM, timers a and b in reload
        wide_reload_value = {16'h0009, 16'h1234, 16'hFFFE};
        wide_duty_value[47:32] = 16'h0003;
        wide_run = 3'h7;
        wide_counter_mode[1] = 1'b1;
        wide_trigger_enable = 3'h7;
        wide_toggle_enable = 3'h3;
        idle(4);
        watch(10, 100);
        check(hi, 16'd30);
        i_event_source_model.pulse(5, 1);
        idle(4);
        watch(3, 20);
        check(ch, 16'd10);
        check({15'h0, ovf_flag[3]}, 16'h0001);
        check({15'h0, wide_toggle_out[1]}, 16'h0001);
        v = cnt(3);
        i_event_source_model.pulse(3, 4);
        idle(2);
        check(cnt(3) - v, 16'd4);
        i_event_source_model.pulse(6, 1);
        idle(2);
        check(cnt(3), 16'h1234);
        wide_mode = 6'h10;
        idle(4);
        v = cnt(4);
        i_event_source_model.pulse(7, 1);
        w = cnt(4);
        check({15'h0, wide_capture[47:32] >= v && wide_capture[47:32] <= w}, 16'h0001);
        $display("test wide done");
    endtask : t_wide

    task automatic complete_run;
        $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    initial begin
        idle(20);
        rst_n = 1'b1;
        t_reset;
        t_legacy_timer;
        t_legacy_b;
        t_legacy_counter;
        t_wide;
        complete_run;
    end
endmodule : tb
